// [hw/nvac_pkg.sv]
// package: constants and types for the data nonvolatile access control block
// Operation
// - read data lands in data register next cycle
// - data register holds until read or write
// - protect fuse never blocks the read path
// - write starts only after 55h, AAh, strobe
// - store strobe refused while store permit clear
// - store permit changed only by software writes
// - clearing permit never aborts a running write
// - completion clears strobe and sets done flag
// - done flag stays set until software clears
// - power-up clears store permit
// - power-up timer blocks writes for 64 ms
package nvac_pkg;
  // ***********************************************************
  // sizes and keys
  // ***********************************************************
  localparam int unsigned NVAC_ADDR_W = 8;
  localparam int unsigned NVAC_DATA_W = 8;
  localparam logic [7:0] NVAC_KEY_FIRST = 8'h55;
  localparam logic [7:0] NVAC_KEY_SECOND = 8'hAA;
  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int unsigned NVAC_CLK_MHZ = 100;
  localparam int unsigned NVAC_PWRUP_MS = 64;
  // milliseconds times cycles per millisecond; kept in order so the product stays inside 32 bits
  localparam int unsigned NVAC_PWRUP_CYC = NVAC_PWRUP_MS * 1000 * NVAC_CLK_MHZ;
  localparam int unsigned NVAC_WRITE_CYC = 400;
  // ***********************************************************
  // states
  // ***********************************************************
  typedef enum logic [1:0] {NVAC_KEY_IDLE, NVAC_KEY_GOT1, NVAC_KEY_ARMED} nvac_key_t;
endpackage

// [hw/nvac_arr_if.sv]
// interface: array access signals between control and storage
`timescale 1ns/1ps
interface nvac_arr_if;
  import nvac_pkg::*;
  logic [NVAC_ADDR_W-1:0] addr;
  logic [NVAC_DATA_W-1:0] wdata;
  logic [NVAC_DATA_W-1:0] rdata;
  logic we;
  modport ctl (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface

// [hw/nvac_array.sv]
// module: byte-wide storage array with combinational read
`timescale 1ns/1ps
module nvac_array
  import nvac_pkg::*;
#(
  parameter int unsigned DEPTH = 256
) (
  input wire logic ref_clk,
  nvac_arr_if.mem arr
);
  // ***********************************************************
  // storage
  // ***********************************************************
  // no reset: contents model nonvolatile cells
  logic [NVAC_DATA_W-1:0] mem_ff [DEPTH];
  always_ff @(posedge ref_clk) begin
    if (arr.we) begin
      mem_ff[arr.addr] <= arr.wdata;
    end
  end
  assign arr.rdata = mem_ff[arr.addr];
endmodule

// [hw/nvac_top.sv]
// module: unlock, permit and write-cycle control for the data array
`timescale 1ns/1ps
module nvac_top
  import nvac_pkg::*;
#(
  parameter int unsigned PWRUP_CYC = NVAC_PWRUP_CYC,
  parameter int unsigned WRITE_CYC = NVAC_WRITE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic addr_wr,
  input wire logic [7:0] addr_wdata,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  input wire logic ctrl_wr,
  input wire logic ctrl_program_space_select,
  input wire logic ctrl_config_space_select,
  input wire logic ctrl_store_permit,
  input wire logic ctrl_store_strobe,
  input wire logic ctrl_read_strobe,
  input wire logic ctrl_clear_done,
  input wire logic key_wr,
  input wire logic [7:0] key_wdata,
  input wire logic data_protect_fuse,
  output logic [7:0] nv_byte_address_reg,
  output logic [7:0] nv_byte_data_reg,
  output logic program_space_select,
  output logic config_space_select,
  output logic store_permit,
  output logic store_strobe,
  output logic store_done_flag,
  output logic pwrup_busy
);
  nvac_arr_if arr ();
  nvac_array #(.DEPTH(256)) nvac_array_i (.ref_clk(ref_clk), .arr(arr));

  // ***********************************************************
  // state
  // ***********************************************************
  logic [7:0] addr_ff, nxt_addr, data_ff, nxt_data;
  logic pgd_ff, nxt_pgd, cfg_ff, nxt_cfg, perm_ff, nxt_perm, wr_ff, nxt_wr, done_ff, nxt_done;
  nvac_key_t key_ff, nxt_key;
  logic [31:0] pwr_ff, nxt_pwr, wcnt_ff, nxt_wcnt;
  logic start, finish, rd_go, pwr_busy;

  assign pwr_busy = (pwr_ff != 32'h0);
  // fuse is deliberately unused: it guards external access only
  assign rd_go = ctrl_wr && ctrl_read_strobe && !ctrl_program_space_select && !ctrl_config_space_select;
  // strobe only honoured with permit already set and key armed
  assign start = ctrl_wr && ctrl_store_strobe && perm_ff && !wr_ff && (key_ff == NVAC_KEY_ARMED) && !pwr_busy;
  assign finish = wr_ff && (wcnt_ff == 32'h1);
  assign arr.addr = addr_ff;
  assign arr.wdata = data_ff;
  assign arr.we = finish;

  // ***********************************************************
  // software-visible registers
  // ***********************************************************
  always_comb begin
    nxt_addr = addr_wr ? addr_wdata : addr_ff;
    nxt_data = data_ff;
    if (rd_go) begin
      nxt_data = arr.rdata;
    end else if (data_wr) begin
      nxt_data = data_wdata;
    end
    nxt_pgd = ctrl_wr ? ctrl_program_space_select : pgd_ff;
    nxt_cfg = ctrl_wr ? ctrl_config_space_select : cfg_ff;
    // only a control write moves permit; the write machine never touches it
    nxt_perm = ctrl_wr ? ctrl_store_permit : perm_ff;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_ff <= 8'h00;
      data_ff <= 8'h00;
      pgd_ff <= 1'b0;
      cfg_ff <= 1'b0;
      perm_ff <= 1'b0;
    end else begin
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
      pgd_ff <= nxt_pgd;
      cfg_ff <= nxt_cfg;
      perm_ff <= nxt_perm;
    end
  end

  // ***********************************************************
  // power-up timer
  // ***********************************************************
  // counts down once per reset and then parks at zero
  always_comb begin
    nxt_pwr = pwr_busy ? pwr_ff - 32'h1 : pwr_ff;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pwr_ff <= PWRUP_CYC;
    end else begin
      pwr_ff <= nxt_pwr;
    end
  end

  // ***********************************************************
  // write cycle and completion flag
  // ***********************************************************
  always_comb begin
    nxt_wr = wr_ff;
    nxt_wcnt = wcnt_ff;
    if (start) begin
      nxt_wr = 1'b1;
      nxt_wcnt = WRITE_CYC;
    end else if (finish) begin
      nxt_wr = 1'b0;
      nxt_wcnt = 32'h0;
    end else if (wr_ff) begin
      nxt_wcnt = wcnt_ff - 32'h1;
    end
    // set wins over a same-cycle clear; enables play no part
    nxt_done = finish ? 1'b1 : ((ctrl_wr && ctrl_clear_done) ? 1'b0 : done_ff);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ff <= 1'b0;
      done_ff <= 1'b0;
      wcnt_ff <= 32'h0;
    end else begin
      wr_ff <= nxt_wr;
      done_ff <= nxt_done;
      wcnt_ff <= nxt_wcnt;
    end
  end

  // ***********************************************************
  // unlock key tracker
  // ***********************************************************
  // any non-key write drops the arming, so one unlock covers one byte only
  always_comb begin
    nxt_key = key_ff;
    if (key_wr) begin
      unique case (key_ff)
        NVAC_KEY_IDLE: nxt_key = (key_wdata == NVAC_KEY_FIRST) ? NVAC_KEY_GOT1 : NVAC_KEY_IDLE;
        NVAC_KEY_GOT1: nxt_key = (key_wdata == NVAC_KEY_SECOND) ? NVAC_KEY_ARMED : NVAC_KEY_IDLE;
        NVAC_KEY_ARMED: nxt_key = (key_wdata == NVAC_KEY_FIRST) ? NVAC_KEY_GOT1 : NVAC_KEY_IDLE;
        default: nxt_key = NVAC_KEY_IDLE;
      endcase
    end else if (addr_wr || data_wr || ctrl_wr) begin
      nxt_key = NVAC_KEY_IDLE;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      key_ff <= NVAC_KEY_IDLE;
    end else begin
      key_ff <= nxt_key;
    end
  end

  assign nv_byte_address_reg = addr_ff;
  assign nv_byte_data_reg = data_ff;
  assign program_space_select = pgd_ff;
  assign config_space_select = cfg_ff;
  assign store_permit = perm_ff;
  assign store_strobe = wr_ff;
  assign store_done_flag = done_ff;
  assign pwrup_busy = pwr_busy;

  // ***********************************************************
  // checks
  // ***********************************************************
  property p_read_next;
    @(posedge ref_clk) disable iff (rst) rd_go |=> (nv_byte_data_reg == $past(arr.rdata));
  endproperty
  a_read_next: assert property (p_read_next) else $error("read data not loaded");

  property p_data_hold;
    @(posedge ref_clk) disable iff (rst) (!rd_go && !data_wr) |=> $stable(nv_byte_data_reg);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data register changed");

  property p_no_permit;
    @(posedge ref_clk) disable iff (rst) (!store_permit && !store_strobe) |=> !store_strobe;
  endproperty
  a_no_permit: assert property (p_no_permit) else $error("strobe set without permit");

  property p_need_key;
    @(posedge ref_clk) disable iff (rst) ($rose(store_strobe)) |-> $past(key_ff == NVAC_KEY_ARMED);
  endproperty
  a_need_key: assert property (p_need_key) else $error("write without unlock");

  property p_permit_sw;
    @(posedge ref_clk) disable iff (rst) !$past(ctrl_wr) |-> $stable(store_permit);
  endproperty
  a_permit_sw: assert property (p_permit_sw) else $error("permit changed by hardware");

  property p_complete;
    @(posedge ref_clk) disable iff (rst) $fell(store_strobe) |-> store_done_flag;
  endproperty
  a_complete: assert property (p_complete) else $error("done not set at completion");

  property p_done_sticky;
    @(posedge ref_clk) disable iff (rst) (store_done_flag && !(ctrl_wr && ctrl_clear_done)) |=> store_done_flag;
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");

  property p_pwrup;
    @(posedge ref_clk) disable iff (rst) pwrup_busy |=> !$rose(store_strobe);
  endproperty
  a_pwrup: assert property (p_pwrup) else $error("write during power-up");

  property p_duration;
    @(posedge ref_clk) disable iff (rst) $rose(store_strobe) |-> (wcnt_ff == WRITE_CYC);
  endproperty
  a_duration: assert property (p_duration) else $error("write length wrong");

  property p_tracker;
    @(posedge ref_clk) disable iff (rst) (!key_wr && (addr_wr || data_wr || ctrl_wr)) |=> key_ff == NVAC_KEY_IDLE;
  endproperty
  a_tracker: assert property (p_tracker) else $error("tracker not reset");

  property p_runs_on;
    @(posedge ref_clk) disable iff (rst) (store_strobe && (wcnt_ff != 32'h1)) |=> store_strobe;
  endproperty
  a_runs_on: assert property (p_runs_on) else $error("write cycle cut short");

  property p_key_used;
    @(posedge ref_clk) disable iff (rst) $rose(store_strobe) |-> (key_ff == NVAC_KEY_IDLE);
  endproperty
  a_key_used: assert property (p_key_used) else $error("unlock left armed after start");

  property p_done_set;
    @(posedge ref_clk) disable iff (rst) finish |=> store_done_flag;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set at completion");
endmodule

// [test/nvac_sw_model.sv]
// partner model: software writing the block's registers one strobe at a time
`timescale 1ns/1ps
module nvac_sw_model (
  input wire logic ref_clk,
  output logic addr_wr, output logic data_wr, output logic key_wr, output logic ctrl_wr,
  output logic [7:0] addr_wdata, output logic [7:0] data_wdata, output logic [7:0] key_wdata,
  output logic ctrl_program_space_select, output logic ctrl_config_space_select,
  output logic ctrl_store_permit, output logic ctrl_store_strobe, output logic ctrl_read_strobe,
  output logic ctrl_clear_done
);
  initial begin
    {addr_wr, data_wr, key_wr, ctrl_wr, addr_wdata, data_wdata, key_wdata} = '0;
    {ctrl_program_space_select, ctrl_config_space_select, ctrl_store_permit} = '0;
    {ctrl_store_strobe, ctrl_read_strobe, ctrl_clear_done} = '0;
  end
  // s: 0 address, 1 data, 2 unlock key, 3 control with fields in v[5:0]
  task automatic put(input int unsigned s, input logic [7:0] v);
    @(negedge ref_clk);
    {addr_wdata, data_wdata, key_wdata} = {3{v}};
    {ctrl_program_space_select, ctrl_config_space_select, ctrl_store_permit, ctrl_store_strobe,
     ctrl_read_strobe, ctrl_clear_done} = v[5:0];
    {addr_wr, data_wr, key_wr, ctrl_wr} = 4'h8 >> s;
    @(negedge ref_clk);
    {addr_wr, data_wr, key_wr, ctrl_wr} = 4'h0;
    // stale data would hide a missed strobe, so the inverse goes out once released
    {addr_wdata, data_wdata, key_wdata} = {3{~v}};
  endtask
endmodule

// [test/nvac_top_tb_top.sv]
// testbench: register-level scenarios for the access control block
`timescale 1ns/1ps
module nvac_top_tb_top;
  import nvac_pkg::*;
  // short counts keep the run brief; expectations follow these values
  localparam int unsigned PWR = 12;
  localparam int unsigned WCYC = 3;
  localparam logic [7:0] C_PERMIT = 8'h08;
  localparam logic [7:0] C_GO = 8'h0C;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic data_protect_fuse = 1'b0;
  logic addr_wr, data_wr, key_wr, ctrl_wr, ctrl_program_space_select, ctrl_config_space_select;
  logic ctrl_store_permit, ctrl_store_strobe, ctrl_read_strobe, ctrl_clear_done;
  logic [7:0] addr_wdata, data_wdata, key_wdata, nv_byte_address_reg, nv_byte_data_reg;
  logic program_space_select, config_space_select, store_permit, store_strobe, store_done_flag, pwrup_busy;
  int fail_count = 0;
  int n_checks = 0;
  always #5 ref_clk = ~ref_clk;
  nvac_sw_model nvac_sw_model_i (.*);
  nvac_top #(.PWRUP_CYC(PWR), .WRITE_CYC(WCYC)) nvac_top_i (.*);
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic put(input int unsigned s, input logic [7:0] v);
    nvac_sw_model_i.put(s, v);
  endtask
  // counts falling edges until the strobe (st=1) or power-up busy falls
  task automatic wait_low(input logic st, output int n);
    n = 0;
    while ((st ? store_strobe : pwrup_busy) === 1'b1) begin
      @(negedge ref_clk);
      n++;
      if (n > 100) begin
        fail_count++;
        end_sim();
      end
    end
  endtask
  task automatic unlock_go();
    put(2, NVAC_KEY_FIRST);
    put(2, NVAC_KEY_SECOND);
    put(3, C_GO);
  endtask
  task automatic refused();
    put(3, C_GO);
    chk("store_strobe", 8'h00, 8'(store_strobe));
  endtask
  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_powerup();
    int n;
    chk("store_permit", 8'h00, 8'(store_permit));
    put(3, C_PERMIT);
    unlock_go();
    chk("pwrup_busy", 8'h01, 8'(pwrup_busy));
    chk("store_strobe", 8'h00, 8'(store_strobe));
    wait_low(1'b0, n);
    chk("store_permit", 8'h01, 8'(store_permit));
  endtask
  task automatic t_write();
    int n;
    put(0, 8'h3C);
    chk("nv_byte_address_reg", 8'h3C, nv_byte_address_reg);
    put(1, 8'hA5);
    unlock_go();
    chk("store_strobe", 8'h01, 8'(store_strobe));
    put(3, 8'h00);
    wait_low(1'b1, n);
    // two strobe-high edges already pass inside the permit-clear write
    chk("write cycles", 8'(WCYC), 8'(n + 2));
    chk("store_done_flag", 8'h01, 8'(store_done_flag));
    chk("store_permit", 8'h00, 8'(store_permit));
    put(1, 8'h00);
    data_protect_fuse = 1'b1;
    put(3, 8'h02);
    chk("nv_byte_data_reg", 8'hA5, nv_byte_data_reg);
    put(0, 8'h11);
    chk("nv_byte_address_reg", 8'h11, nv_byte_address_reg);
    chk("nv_byte_data_reg", 8'hA5, nv_byte_data_reg);
    // address 11h was never written, so a read that slips through shows as unknown
    put(3, 8'h22);
    chk("program_space_select", 8'h01, 8'(program_space_select));
    chk("nv_byte_data_reg", 8'hA5, nv_byte_data_reg);
    put(3, 8'h12);
    chk("config_space_select", 8'h01, 8'(config_space_select));
    chk("program_space_select", 8'h00, 8'(program_space_select));
    chk("nv_byte_data_reg", 8'hA5, nv_byte_data_reg);
    chk("store_done_flag", 8'h01, 8'(store_done_flag));
    put(3, 8'h01);
    chk("store_done_flag", 8'h00, 8'(store_done_flag));
  endtask
  task automatic t_refuse();
    int n;
    put(3, C_PERMIT);
    put(2, NVAC_KEY_SECOND);
    put(2, NVAC_KEY_FIRST);
    refused();
    put(2, NVAC_KEY_FIRST);
    put(0, 8'h3C);
    put(2, NVAC_KEY_SECOND);
    refused();
    put(2, NVAC_KEY_FIRST);
    put(2, 8'h5A);
    put(2, NVAC_KEY_SECOND);
    refused();
    put(3, 8'h00);
    put(2, NVAC_KEY_FIRST);
    put(2, NVAC_KEY_SECOND);
    refused();
    unlock_go();
    wait_low(1'b1, n);
    refused();
  endtask
  task automatic t_reset();
    int n;
    put(3, C_PERMIT);
    chk("store_permit", 8'h01, 8'(store_permit));
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("store_permit", 8'h00, 8'(store_permit));
    chk("config_space_select", 8'h00, 8'(config_space_select));
    rst = 1'b0;
    chk("pwrup_busy", 8'h01, 8'(pwrup_busy));
    wait_low(1'b0, n);
    chk("powerup cycles", 8'(PWR), 8'(n));
  endtask
  initial begin
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    t_powerup();
    t_write();
    t_refuse();
    t_reset();
    end_sim();
  end
endmodule
